//--- rtl/cssi_top.sv
// Clocked serial channel: AHB-Lite registers, status, interrupts and frame sequencing.
// Operation
// - Status byte: busy bit 7, overrun bit 0.
// - Busy bit read-only, shows transfer under way.
// - Status reads zero after reset.
// - Power bit cleared also clears status.
// - Two interrupts; receive-complete has higher priority.
// - Receive-complete when data reaches receive buffer.
// - Overrun also raises receive-complete.
// - Single mode: receive-complete after every frame.
// - Continuous transmit: buffer-writable after buffer moves.
// - Single transmit modes: no buffer-writable interrupt.
// - Clock code 000: master, clock divided two.
// - Clock code 111: slave on external clock.
// - Order, polarity and length codes select defaults.
// - Master stops clock when no new data; continuous receive-only mode keeps clocking.
// - Overrun cleared by writing zero.
// - Unread buffer at frame end sets overrun in continuous mode only.
// - Lengths 8 to 16 bits, low aligned.
`include "cssi_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module cssi_top
  import cssi_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // AHB-Lite slave port.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // Serial link pins.
  input wire logic SERIAL_CLOCK_PIN_IN,
  output logic SERIAL_CLOCK_PIN_OUT,
  output logic SERIAL_CLOCK_PIN_OE,
  output logic SERIAL_OUT_PIN,
  input wire logic SERIAL_IN_PIN,
  // Interrupt requests, one-cycle pulses.
  output logic RX_COMPLETE_IRQ,
  output logic TX_BUFFER_WRITABLE_IRQ
);
  // Bus address phase held for the data phase.
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic [2:0] ap_size;
  logic next_ap_valid;
  logic next_ap_write;
  logic [7:0] next_ap_addr;
  logic [2:0] next_ap_size;
  logic [31:0] next_hrdata;
  logic accept; // An address phase is taken this cycle.
  logic rd_rx; // The receive buffer is read this cycle.

  // Software registers.
  logic [7:0] serial_control_primary;
  logic [7:0] serial_clock_control;
  logic [7:0] serial_length_control;
  logic overrun_flag;
  logic [15:0] transmit_buffer;
  logic [15:0] receive_buffer;
  logic [7:0] next_ctl;
  logic [7:0] next_clk;
  logic [7:0] next_len;
  logic next_ove;
  logic [15:0] next_txb;
  logic [15:0] next_rxb;

  // Sequencer state.
  cssi_state_t state;
  cssi_state_t next_state;
  logic tx_full; // Transmit buffer holds data not yet sent.
  logic rx_unread; // Receive buffer holds data not yet read.
  logic rx_go; // A receive-only frame is requested.
  logic [5:0] edge_cnt; // Clock edges seen in this frame.
  logic next_tx_full;
  logic next_rx_unread;
  logic next_rx_go;
  logic [5:0] next_edge_cnt;
  logic next_rx_irq;
  logic next_tx_irq;

  // Decoded settings and frame events.
  logic pwr;
  logic txe;
  logic rxe;
  logic cont;
  logic master;
  logic [4:0] len;
  logic transfer_in_progress_flag;
  logic [7:0] serial_status;
  logic lead;
  logic trail;
  logic last;
  logic frame_end;
  logic again;
  logic load;
  logic present;
  logic capture;
  logic [15:0] rx_word;
  logic [3:0] lanes;
  logic wr;
  logic [7:0] wofs;

  assign pwr = serial_control_primary[`CSSI_CTL_PWR];
  assign txe = serial_control_primary[`CSSI_CTL_TXE];
  assign rxe = serial_control_primary[`CSSI_CTL_RXE];
  assign cont = serial_control_primary[`CSSI_CTL_CONT];
  assign master = serial_clock_control[2:0] != `CSSI_CKS_SLAVE;
  assign len = cssi_frame_bits(serial_length_control[3:0]);
  assign transfer_in_progress_flag = state == ST_FRAME;
  assign serial_status = {transfer_in_progress_flag, 6'h00, overrun_flag};
  assign accept = HSEL && HREADY && HTRANS[1];
  assign rd_rx = accept && !HWRITE && ({HADDR[7:2], 2'h0} == `CSSI_OFS_RX);
  assign HREADYOUT = 1'h1;
  assign HRESP = 1'h0;
  assign SERIAL_CLOCK_PIN_OE = master && pwr;

  // Master clock divider or slave edge detector.
  cssi_clkgen u_clkgen (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .master(master),
    .run(transfer_in_progress_flag),
    .cks(serial_clock_control[2:0]),
    .idle_lvl(!serial_clock_control[`CSSI_CLK_CKP]),
    .sck_in(SERIAL_CLOCK_PIN_IN),
    .sck_out(SERIAL_CLOCK_PIN_OUT),
    .lead(lead),
    .trail(trail)
  );

  // Data shifter on the serial lines.
  cssi_shifter u_shifter (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .load(load),
    .load_data(txe ? transmit_buffer : 16'h0000),
    .present(present),
    .capture(capture),
    .dir(serial_control_primary[`CSSI_CTL_DIR]),
    .len(len),
    .si(SERIAL_IN_PIN),
    .so(SERIAL_OUT_PIN),
    .rx_word(rx_word)
  );

  // Bus group: holds the address phase and registers read data for the data phase.
  always_comb begin
    next_ap_valid = accept;
    next_ap_write = accept && HWRITE;
    next_ap_addr = accept ? HADDR[7:0] : ap_addr;
    next_ap_size = accept ? HSIZE : ap_size;
    next_hrdata = 32'h00000000;
    if (accept && !HWRITE) begin
      unique case ({HADDR[7:2], 2'h0})
        `CSSI_OFS_CTL: next_hrdata = {24'h000000, serial_control_primary};
        `CSSI_OFS_CLK: next_hrdata = {24'h000000, serial_clock_control};
        `CSSI_OFS_LEN: next_hrdata = {24'h000000, serial_length_control};
        `CSSI_OFS_STAT: next_hrdata = {24'h000000, serial_status};
        `CSSI_OFS_TX: next_hrdata = {16'h0000, transmit_buffer};
        `CSSI_OFS_RX: next_hrdata = {16'h0000, receive_buffer};
        // Unmapped addresses read zero with an OKAY response.
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Registers the bus group.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ap_valid <= 1'h0;
      ap_write <= 1'h0;
      ap_addr <= 8'h00;
      ap_size <= 3'h0;
      HRDATA <= 32'h00000000;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      ap_size <= next_ap_size;
      HRDATA <= next_hrdata;
    end
  end

  // Core group: register writes, frame sequencing, status and interrupts.
  always_comb begin
    wr = ap_valid && ap_write;
    lanes = cssi_lanes(ap_size, ap_addr[1:0]);
    wofs = {ap_addr[7:2], 2'h0};
    next_ctl = serial_control_primary;
    next_clk = serial_clock_control;
    next_len = serial_length_control;
    next_ove = overrun_flag;
    next_txb = transmit_buffer;
    next_rxb = receive_buffer;
    next_state = state;
    next_tx_full = tx_full;
    next_rx_unread = rx_unread;
    next_rx_go = rx_go;
    next_edge_cnt = edge_cnt;
    next_rx_irq = 1'h0;
    next_tx_irq = 1'h0;
    // Frame events; a frame is two edges per bit.
    last = (lead || trail) && (edge_cnt == ({len, 1'h0} - 6'h01));
    frame_end = transfer_in_progress_flag && last;
    again = cont && (txe ? tx_full : rxe);
    load = pwr && (txe || rxe) &&
           (((state == ST_IDLE) && (txe ? tx_full : rx_go)) || (frame_end && again));
    if (serial_clock_control[`CSSI_CLK_DAP]) begin
      present = load || (trail && !last);
      capture = lead;
    end else begin
      present = lead;
      capture = trail;
    end
    // Software writes; the busy bit ignores writes.
    if (wr && lanes[0]) begin
      unique case (wofs)
        `CSSI_OFS_CTL: next_ctl = HWDATA[7:0];
        `CSSI_OFS_CLK: next_clk = {3'h0, HWDATA[4:0]};
        `CSSI_OFS_LEN: next_len = {4'h0, HWDATA[3:0]};
        `CSSI_OFS_STAT: next_ove = overrun_flag && HWDATA[`CSSI_STAT_OVE];
        `CSSI_OFS_TX: next_txb[7:0] = HWDATA[7:0];
        default: next_ctl = serial_control_primary;
      endcase
    end
    if (wr && lanes[1] && (wofs == `CSSI_OFS_TX)) begin
      next_txb[15:8] = HWDATA[15:8];
    end
    // Buffer fill flag; a new write wins over the move into the shifter.
    if (wr && (lanes[1:0] != 2'h0) && (wofs == `CSSI_OFS_TX)) begin
      next_tx_full = 1'h1;
    end else if (load && txe) begin
      next_tx_full = 1'h0;
    end
    // Receive-only frames start on a read of the receive buffer.
    if (rd_rx && rxe && !txe) begin
      next_rx_go = 1'h1;
    end else if (load) begin
      next_rx_go = 1'h0;
    end
    if (rd_rx) begin
      next_rx_unread = 1'h0;
    end
    // Buffer moved into the shifter in a continuous transmit mode.
    if (load && txe && cont) begin
      next_tx_irq = 1'h1;
    end
    // Edge counting and the busy state.
    if (load) begin
      next_edge_cnt = 6'h00;
      next_state = ST_FRAME;
    end else if (frame_end) begin
      next_state = ST_IDLE;
    end else if (lead || trail) begin
      next_edge_cnt = edge_cnt + 6'h01;
    end
    // End of frame: move received data and report it.
    if (frame_end) begin
      if (rxe) begin
        next_rxb = rx_word;
        next_rx_unread = 1'h1;
        if (cont && rx_unread && !rd_rx) begin
          next_ove = 1'h1;
        end
      end
      if (rxe || !cont) begin
        next_rx_irq = 1'h1;
      end
    end
    // Power off stops the channel and clears the status.
    if (!next_ctl[`CSSI_CTL_PWR]) begin
      next_state = ST_IDLE;
      next_ove = 1'h0;
      next_tx_full = 1'h0;
      next_rx_go = 1'h0;
      next_edge_cnt = 6'h00;
      next_tx_irq = 1'h0;
    end
  end

  // Registers the core group; all status reads zero after reset.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      serial_control_primary <= `CSSI_CTL_RST;
      serial_clock_control <= `CSSI_CLK_RST;
      serial_length_control <= `CSSI_LEN_RST;
      overrun_flag <= 1'h0;
      state <= ST_IDLE;
      transmit_buffer <= 16'h0000;
      receive_buffer <= 16'h0000;
      tx_full <= 1'h0;
      rx_unread <= 1'h0;
      rx_go <= 1'h0;
      edge_cnt <= 6'h00;
      RX_COMPLETE_IRQ <= 1'h0;
      TX_BUFFER_WRITABLE_IRQ <= 1'h0;
    end else begin
      serial_control_primary <= next_ctl;
      serial_clock_control <= next_clk;
      serial_length_control <= next_len;
      overrun_flag <= next_ove;
      state <= next_state;
      transmit_buffer <= next_txb;
      receive_buffer <= next_rxb;
      tx_full <= next_tx_full;
      rx_unread <= next_rx_unread;
      rx_go <= next_rx_go;
      edge_cnt <= next_edge_cnt;
      RX_COMPLETE_IRQ <= next_rx_irq;
      TX_BUFFER_WRITABLE_IRQ <= next_tx_irq;
    end
  end
endmodule
`default_nettype wire

//--- rtl/cssi_cfg.svh
// Offsets, field positions, reset values and clock settings of the serial channel.
`ifndef CSSI_CFG_SVH
`define CSSI_CFG_SVH
`define CSSI_OFS_CTL 8'h00
`define CSSI_OFS_CLK 8'h04
`define CSSI_OFS_LEN 8'h08
`define CSSI_OFS_STAT 8'h0C
`define CSSI_OFS_TX 8'h10
`define CSSI_OFS_RX 8'h14
`define CSSI_CTL_PWR 7
`define CSSI_CTL_TXE 6
`define CSSI_CTL_RXE 5
`define CSSI_CTL_DIR 4
`define CSSI_CTL_CONT 1
`define CSSI_CLK_CKP 4
`define CSSI_CLK_DAP 3
`define CSSI_STAT_TSF 7
`define CSSI_STAT_OVE 0
`define CSSI_CTL_RST 8'h00
`define CSSI_CLK_RST 8'h00
`define CSSI_LEN_RST 8'h00
`define CSSI_STAT_RST 8'h00
`define CSSI_CKS_DIV2 3'h0
`define CSSI_CKS_BRG 3'h6
`define CSSI_CKS_SLAVE 3'h7
`define CSSI_BRG_HALF 6'h01
`endif

//--- rtl/cssi_pkg.sv
// Types and shared helper functions of the serial channel.
package cssi_pkg;
  // Sequencer states: no frame, or a frame on the link.
  typedef enum logic {ST_IDLE, ST_FRAME} cssi_state_t;

  // Frame length in bits from the length code: 8 to 15, or 16 when the top bit is set.
  function automatic logic [4:0] cssi_frame_bits(input logic [3:0] code);
    return code[3] ? 5'h10 : {2'h1, code[2:0]};
  endfunction

  // Byte lanes touched by an AHB transfer of the given size and low address bits.
  function automatic logic [3:0] cssi_lanes(input logic [2:0] size, input logic [1:0] ofs);
    if (size == 3'h0) begin
      return 4'h1 << ofs;
    end else if (size == 3'h1) begin
      return ofs[1] ? 4'hC : 4'h3;
    end
    return 4'hF;
  endfunction
endpackage

//--- rtl/cssi_clkgen.sv
// Serial clock generator for master mode and edge detector for slave mode.
`timescale 1ns/100ps
`default_nettype none
module cssi_clkgen
  import cssi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Mode and frame control.
  input wire logic master,
  input wire logic run,
  input wire logic [2:0] cks,
  input wire logic idle_lvl,
  // Pin side.
  input wire logic sck_in,
  output logic sck_out,
  // Edge events, valid in the cycle the edge is decided or seen.
  output logic lead,
  output logic trail
);
  logic [5:0] cnt; // Half period counter.
  logic [5:0] next_cnt;
  logic next_sck;
  logic sck_prev; // Pin level of the previous cycle.
  logic [5:0] half_m1; // Half period length minus one.
  logic tick; // Master clock toggles at the next edge.

  // Divider and edge events; a code of 000 gives a half period of one cycle.
  always_comb begin
    if (cks == `CSSI_CKS_BRG) begin
      half_m1 = `CSSI_BRG_HALF - 6'h01;
    end else begin
      half_m1 = (6'h01 << cks) - 6'h01;
    end
    tick = master && run && (cnt == half_m1);
    if (master) begin
      lead = tick && (sck_out == idle_lvl);
      trail = tick && (sck_out != idle_lvl);
    end else begin
      // The external pin is taken as synchronous to the system clock.
      lead = run && (sck_prev == idle_lvl) && (sck_in != idle_lvl);
      trail = run && (sck_prev != idle_lvl) && (sck_in == idle_lvl);
    end
    if (!master || !run) begin
      next_cnt = 6'h00;
      next_sck = idle_lvl;
    end else if (tick) begin
      next_cnt = 6'h00;
      next_sck = !sck_out;
    end else begin
      next_cnt = cnt + 6'h01;
      next_sck = sck_out;
    end
  end

  // Registers the divider, the driven level and the pin history.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 6'h00;
      sck_out <= 1'h1;
      sck_prev <= 1'h1;
    end else begin
      cnt <= next_cnt;
      sck_out <= next_sck;
      sck_prev <= sck_in;
    end
  end
endmodule
`default_nettype wire

//--- rtl/cssi_shifter.sv
// Bit-indexed transmit and receive shifter with selectable bit order and length.
`timescale 1ns/100ps
`default_nettype none
module cssi_shifter
  import cssi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Frame control.
  input wire logic load,
  input wire logic [15:0] load_data,
  input wire logic present,
  input wire logic capture,
  input wire logic dir,
  input wire logic [4:0] len,
  // Serial data.
  input wire logic si,
  output logic so,
  // Received word including a capture made in this cycle.
  output logic [15:0] rx_word
);
  logic [15:0] tx_data; // Word being sent.
  logic [15:0] rx_data; // Bits captured so far; unused high bits stay zero.
  logic [4:0] out_idx; // Next bit to present.
  logic [4:0] in_idx; // Next bit to capture.
  logic [15:0] next_tx;
  logic [15:0] next_rx;
  logic [4:0] next_out;
  logic [4:0] next_in;
  logic next_so;

  // Buffer position of the n-th bit on the line, low end aligned.
  function automatic logic [3:0] bit_pos(input logic [4:0] n, input logic d, input logic [4:0] l);
    logic [4:0] p;
    p = d ? n : (l - 5'h01 - n);
    return p[3:0];
  endfunction

  // Captures first, then a load starts a fresh frame.
  always_comb begin
    next_tx = tx_data;
    next_rx = rx_data;
    next_out = out_idx;
    next_in = in_idx;
    next_so = so;
    if (capture) begin
      next_rx[bit_pos(in_idx, dir, len)] = si;
      next_in = in_idx + 5'h01;
    end
    rx_word = next_rx;
    if (load) begin
      next_tx = load_data;
      next_rx = 16'h0000;
      next_in = 5'h00;
      next_out = 5'h00;
      if (present) begin
        next_so = load_data[bit_pos(5'h00, dir, len)];
        next_out = 5'h01;
      end
    end else if (present) begin
      next_so = tx_data[bit_pos(out_idx, dir, len)];
      next_out = out_idx + 5'h01;
    end
  end

  // Registers the shifter state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_data <= 16'h0000;
      rx_data <= 16'h0000;
      out_idx <= 5'h00;
      in_idx <= 5'h00;
      so <= 1'h1;
    end else begin
      tx_data <= next_tx;
      rx_data <= next_rx;
      out_idx <= next_out;
      in_idx <= next_in;
      so <= next_so;
    end
  end
endmodule
`default_nettype wire

//--- tb/cssi_sva.sv
// Port-level checks of the serial channel, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module cssi_sva (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Bus side.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  // Link and interrupts.
  input wire logic SERIAL_CLOCK_PIN_OUT,
  input wire logic SERIAL_CLOCK_PIN_OE,
  input wire logic SERIAL_OUT_PIN,
  input wire logic RX_COMPLETE_IRQ,
  input wire logic TX_BUFFER_WRITABLE_IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // A read request is taken at this edge.
  logic rd_req;
  assign rd_req = HSEL && HREADY && HTRANS[1] && !HWRITE;
  // A read of the status byte.
  sequence status_read;
    rd_req && HADDR[7:0] == 8'h0C;
  endsequence
  // A falling serial clock while the channel drives it.
  sequence lead_edge;
    SERIAL_CLOCK_PIN_OE && $fell(SERIAL_CLOCK_PIN_OUT);
  endsequence
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
  a_reset_idle: assert property ($fell(RST) |-> SERIAL_CLOCK_PIN_OUT && SERIAL_OUT_PIN
    && !SERIAL_CLOCK_PIN_OE && !RX_COMPLETE_IRQ && !TX_BUFFER_WRITABLE_IRQ)
    else $error("link not idle after reset");
  a_rdata_idle: assert property (!$past(rd_req) |-> HRDATA == 32'h0)
    else $error("read data outside a data phase");
  a_status_zeros: assert property (status_read |=> HRDATA[31:8] == 24'h0 && HRDATA[6:1] == 6'h0)
    else $error("status unused bits not zero");
  a_rx_pulse: assert property (RX_COMPLETE_IRQ |=> !RX_COMPLETE_IRQ)
    else $error("receive pulse longer than one cycle");
  a_tx_pulse: assert property (TX_BUFFER_WRITABLE_IRQ |=> !TX_BUFFER_WRITABLE_IRQ)
    else $error("buffer pulse longer than one cycle");
  a_half_period: assert property (lead_edge |=> $rose(SERIAL_CLOCK_PIN_OUT))
    else $error("serial clock not system clock halved");
  a_out_on_lead: assert property (SERIAL_CLOCK_PIN_OE && $changed(SERIAL_OUT_PIN) |-> lead_edge)
    else $error("data out changed off the leading edge");
endmodule
bind cssi_top cssi_sva cssi_sva_i (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .HRDATA(HRDATA), .SERIAL_CLOCK_PIN_OUT(SERIAL_CLOCK_PIN_OUT),
  .SERIAL_CLOCK_PIN_OE(SERIAL_CLOCK_PIN_OE), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
  .RX_COMPLETE_IRQ(RX_COMPLETE_IRQ), .TX_BUFFER_WRITABLE_IRQ(TX_BUFFER_WRITABLE_IRQ));
`default_nettype wire

//--- tb/cssi_peer.sv
// Serial peer on the far side of the link, type 1, MSB first, 8-bit words.
`timescale 1ns/100ps
`default_nettype none
module cssi_peer (
  // System clock, paces the peer's own serial clock.
  input wire logic clk_sys,
  // Link from the channel.
  input wire logic sck_mst,
  input wire logic sck_oe,
  input wire logic so,
  // Word to send and start of a peer-clocked frame.
  input wire logic [7:0] tx_word,
  input wire logic go,
  // Link toward the channel and the last word captured.
  output logic sck_slv,
  output logic si,
  output logic [7:0] rx_word
);
  // Bit position within the 8-bit word.
  int cnt = 0;
  // Line clock: the channel's when it surely drives, else ours; an unknown enable makes no edge.
  logic lclk;
  assign lclk = (sck_oe === 1'b1) ? sck_mst : sck_slv;
  // Our clock idles high and stands still outside frames.
  initial begin
    sck_slv = 1'b1;
    si = 1'b0;
    rx_word = 8'h00;
    // Edges seen while the line settles at power-up are not bits.
    #1;
    cnt = 0;
  end
  // Leading edge shows the next bit, MSB first.
  always @(negedge lclk) begin
    si <= tx_word[7 - cnt];
  end
  // Trailing edge captures; after the last bit the line is released and flips.
  always @(posedge lclk) begin
    rx_word <= {rx_word[6:0], so};
    cnt <= (cnt == 7) ? 0 : cnt + 1;
    if (cnt == 7) begin
      si <= #(sck_oe ? 30 : 200) ~si;
    end
  end
  // Slave-mode frame: eight clocks of four system cycles per half.
  always @(posedge go) begin
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge clk_sys);
      sck_slv <= 1'b0;
      repeat (4) @(posedge clk_sys);
      sck_slv <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/cssi_top_bench.sv
// Self-checking bench of the serial channel with a peer on the link.
`timescale 1ns/100ps
`default_nettype none
`include "cssi_cfg.svh"
module cssi_top_bench;
  // Bus and link signals.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic prev_sck = 1'b1;
  logic hready, hready_o, hresp, sck_in, sck_out, sck_oe, so, si, rx_irq, tx_irq;
  logic [31:0] hrdata;
  logic [7:0] peer_rx;
  // Event counters and the verdict counters.
  int rx_cnt = 0, tx_cnt = 0, fall_cnt = 0, cyc = 0, miscompares = 0, check_count = 0;
  assign hready = hready_o;
  always #20 clk = ~clk;
  cssi_top cssi_top_i (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready_o),
    .HRESP(hresp), .HRDATA(hrdata), .SERIAL_CLOCK_PIN_IN(sck_in),
    .SERIAL_CLOCK_PIN_OUT(sck_out), .SERIAL_CLOCK_PIN_OE(sck_oe), .SERIAL_OUT_PIN(so),
    .SERIAL_IN_PIN(si), .RX_COMPLETE_IRQ(rx_irq), .TX_BUFFER_WRITABLE_IRQ(tx_irq));
  cssi_peer cssi_peer_i (.clk_sys(clk), .sck_mst(sck_out), .sck_oe(sck_oe), .so(so),
    .tx_word(8'h3C), .go(go), .sck_slv(sck_in), .si(si), .rx_word(peer_rx));
  // Counts pulses and driven clock falls; cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_sck <= sck_out;
    if (rx_irq === 1'b1) rx_cnt <= rx_cnt + 1;
    if (tx_irq === 1'b1) tx_cnt <= tx_cnt + 1;
    if (sck_oe === 1'b1 && prev_sck === 1'b1 && sck_out === 1'b0) fall_cnt <= fall_cnt + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // Compares one value and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One single word transfer, entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hready_o !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hready_o !== 1'b1);
    // Read data is taken at the edge that ends the data phase.
    q = hrdata;
  endtask
  // Register write and read.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // Waits for a counter to reach a target; the bench timeout bounds the wait.
  task automatic wait_cnt(ref int c, input int target);
    while (c < target) @(posedge clk);
  endtask
  // Polls the status until the busy bit is clear.
  task automatic wait_idle(output logic [31:0] st);
    do begin
      rd(`CSSI_OFS_STAT, st);
    end while (st[7] !== 1'b0);
  endtask
  // Reset value, unmapped place and read-only busy bit.
  task automatic t_regs();
    logic [31:0] q;
    rd(`CSSI_OFS_STAT, q);
    check(q, 32'h0);
    rd(8'h40, q);
    check(q, 32'h0);
    wr(`CSSI_OFS_STAT, 32'h81);
    rd(`CSSI_OFS_STAT, q);
    check(q, 32'h0);
    $display("test regs done");
  endtask
  // Single transfers, full duplex then transmit only, master at half rate.
  task automatic t_single();
    logic [31:0] q;
    logic [7:0] m [2] = '{8'hE0, 8'hC0};
    int f0, r0, t0;
    r0 = rx_cnt;
    t0 = tx_cnt;
    for (int i = 0; i < 2; i++) begin
      wr(`CSSI_OFS_CTL, {24'h0, m[i]});
      f0 = fall_cnt;
      wr(`CSSI_OFS_TX, 32'hA5);
      @(posedge clk);
      rd(`CSSI_OFS_STAT, q);
      check(q, 32'h80);
      wait_cnt(rx_cnt, r0 + i + 1);
      wait_idle(q);
      check(q, 32'h0);
      check(peer_rx, 8'hA5);
      check(fall_cnt - f0, 8);
      rd(`CSSI_OFS_RX, q);
      if (i == 0) check(q, 32'h3C);
    end
    check(rx_cnt - r0, 2);
    check(tx_cnt - t0, 0);
    $display("test single done");
  endtask
  // Two chained frames left unread; overrun cleared by write, then by power off.
  task automatic t_cont();
    logic [31:0] q;
    int f0, r0, t0;
    for (int k = 0; k < 2; k++) begin
      r0 = rx_cnt;
      t0 = tx_cnt;
      wr(`CSSI_OFS_CTL, 32'hE2);
      wr(`CSSI_OFS_TX, 32'h11);
      wait_cnt(tx_cnt, t0 + 1);
      wr(`CSSI_OFS_TX, 32'h22);
      wait_idle(q);
      check(q, 32'h01);
      check(rx_cnt - r0, 2);
      check(tx_cnt - t0, 2);
      check(peer_rx, 8'h22);
      f0 = fall_cnt;
      repeat (20) @(posedge clk);
      check(fall_cnt - f0, 0);
      rd(`CSSI_OFS_RX, q);
      check(q, 32'h3C);
      rd(`CSSI_OFS_STAT, q);
      check(q, 32'h01);
      if (k == 0) wr(`CSSI_OFS_STAT, 32'h0);
      else wr(`CSSI_OFS_CTL, 32'h02);
      rd(`CSSI_OFS_STAT, q);
      check(q, 32'h0);
    end
    $display("test continuous done");
  endtask
  // Slave frame clocked by the peer.
  task automatic t_slave();
    logic [31:0] q;
    int r0;
    r0 = rx_cnt;
    wr(`CSSI_OFS_CLK, 32'h07);
    wr(`CSSI_OFS_CTL, 32'hE0);
    @(posedge clk);
    check(sck_oe, 1'b0);
    wr(`CSSI_OFS_TX, 32'h5A);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_cnt(rx_cnt, r0 + 1);
    wait_idle(q);
    check(peer_rx, 8'h5A);
    rd(`CSSI_OFS_RX, q);
    check(q, 32'h3C);
    wr(`CSSI_OFS_CLK, 32'h00);
    $display("test slave done");
  endtask
  // Frame lengths 16 bits MSB first and 11 bits LSB first; unused receive bits read zero.
  task automatic t_length();
    logic [31:0] q;
    logic [3:0] code [2] = '{4'h8, 4'h3};
    logic [7:0] ctl [2] = '{8'hE0, 8'hF0};
    logic [31:0] want [2] = '{32'h3C3C, 32'h043C};
    int bits [2] = '{16, 11};
    int f0;
    for (int i = 0; i < 2; i++) begin
      wr(`CSSI_OFS_CTL, 32'h00);
      wr(`CSSI_OFS_LEN, {28'h0, code[i]});
      wr(`CSSI_OFS_CTL, {24'h0, ctl[i]});
      f0 = fall_cnt;
      wr(`CSSI_OFS_TX, 32'hFFFF);
      wait_cnt(rx_cnt, rx_cnt + 1);
      wait_idle(q);
      check(fall_cnt - f0, bits[i]);
      rd(`CSSI_OFS_RX, q);
      check(q, want[i]);
    end
    $display("test length done");
  endtask
  // Reset for six cycles, then the scenarios.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_single();
    t_cont();
    t_slave();
    t_length();
    final_report();
  end
endmodule
`default_nettype wire
